//--- hdl/pcs_pkg.sv
// constants for the port pin configuration subregisters
// assumes an 8-bit port address / port control register pair
package pcs_pkg;
   localparam int PCS_PINS = 8;
   // subregister indices held in the port address register
   localparam logic [7:0] PCS_IDX_ALT_ENABLE = 8'h02;
   localparam logic [7:0] PCS_IDX_OUT_CTRL = 8'h03;
   localparam logic [7:0] PCS_IDX_HIGH_DRIVE = 8'h04;
   localparam logic [7:0] PCS_IDX_WAKE_SRC = 8'h05;
   localparam logic [7:0] PCS_IDX_PULLUP = 8'h06;
   localparam logic [7:0] PCS_IDX_ALT_SEL_ONE = 8'h07;
   // reset values
   localparam logic [7:0] PCS_RST_ZERO = 8'h00;
   localparam logic [7:0] PCS_RST_PORT_ABC = 8'h00;
   localparam logic [7:0] PCS_RST_PORT_D = 8'h01;
   localparam logic [7:0] PCS_RST_PORT_A_SMALL = 8'h04;
   localparam logic [7:0] PCS_RST_ADDR = 8'h00;
   localparam logic [7:0] PCS_RD_UNMAPPED = 8'h00;
endpackage

//--- hdl/pcs_wake_if.sv
// wake detection signals between the port top and its detector
// assumes pin levels are already synchronised to clk
`timescale 1ns/1ps
interface pcs_wake_if;
   logic [7:0] pin_level;
   logic [7:0] source_en;
   logic stop_mode;
   logic wake;
   modport det (
      input pin_level,
      input source_en,
      input stop_mode,
      output wake
   );
   modport top (
      output pin_level,
      output source_en,
      output stop_mode,
      input wake
   );
endinterface

//--- hdl/pcs_wake_detect.sv
// edge detector for stop-mode recovery sources
// assumes synchronised pin levels and one clock with sync reset
`timescale 1ns/1ps
module pcs_wake_detect
   import pcs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link to top
   pcs_wake_if.det wk
);
   logic [7:0] prev_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_q <= PCS_RST_ZERO;
      end else begin
         prev_q <= wk.pin_level;
      end
   end

   // any transition, either direction, on an enabled pin
   assign wk.wake = wk.stop_mode &
      (|((wk.pin_level ^ prev_q) & wk.source_en));
endmodule

//--- hdl/pcs_port_cfg.sv
// pin configuration subregisters of one 8-pin port
// assumes a cpu strobing the address/control registers on clk
//
// Behaviour
// - index 04H reaches the high-drive subregister, cleared at reset.
// - high-drive bit selects strong drive, also under alternate function.
// - index 05H reaches the wake-source subregister, cleared at reset.
// - in stop mode a transition on an enabled pin requests wake, except in the first three edges after reset.
// - index 06H reaches the pull-up subregister; one enables pull-up.
// - pull-up reset is 00H ports A-C, 01H port D, 04H small A.
// - index 07H reaches alternate set-1 subregister, cleared at reset.
// - set-1 choice applies only where the alternate enable is set.
// - index 02H reaches alternate enable; zero leaves direction bit.
// - index 03H reaches output control; one forces open drain.
`timescale 1ns/1ps
module pcs_port_cfg
   import pcs_pkg::*;
#(
   parameter logic [7:0] PULLUP_RESET = PCS_RST_PORT_ABC,
   parameter logic [7:0] ALT_ENABLE_RESET = PCS_RST_PORT_ABC,
   parameter logic [7:0] OUT_CTRL_RESET = PCS_RST_PORT_ABC
)(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // cpu side: address and control registers
   input wire logic addr_wr,
   input wire logic addr_rd,
   input wire logic ctl_wr,
   input wire logic ctl_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata_q,
   // from the rest of the port
   input wire logic [7:0] pin_direction_bit,
   input wire logic [7:0] alt_output_en,
   input wire logic stop_mode,
   // raw pad levels, asynchronous
   input wire logic [7:0] pad_in,
   // to the pads
   output logic [7:0] pin_high_drive_q,
   output logic [7:0] pin_pullup_q,
   output logic [7:0] pin_source_en_q,
   output logic [7:0] pin_output_en_q,
   // to the alternate function mux
   output logic [7:0] pin_alt_active_q,
   output logic [7:0] pin_alt_select_one_q,
   // stop-mode recovery request, one-cycle pulse
   output logic wake_req_q
);
   logic [7:0] addr_q;
   logic [7:0] alt_func_enable_reg_q;
   logic [7:0] output_control_reg_q;
   logic [7:0] high_drive_enable_q;
   logic [7:0] stop_wake_source_enable_q;
   logic [7:0] pullup_enable_q;
   logic [7:0] alt_func_select_one_q;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] rd_d;
   // wake arming and per-pin output enable
   logic [2:0] wake_arm_q;
   wire [7:0] pin_output_en_d;
   pcs_wake_if wk ();

   // control write uses the index held before any same-cycle address write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         addr_q <= PCS_RST_ADDR;
      end else if (addr_wr) begin
         addr_q <= cpu_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alt_func_enable_reg_q <= ALT_ENABLE_RESET;
      end else if (ctl_wr && addr_q == PCS_IDX_ALT_ENABLE) begin
         alt_func_enable_reg_q <= cpu_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         output_control_reg_q <= OUT_CTRL_RESET;
      end else if (ctl_wr && addr_q == PCS_IDX_OUT_CTRL) begin
         output_control_reg_q <= cpu_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         high_drive_enable_q <= PCS_RST_ZERO;
      end else if (ctl_wr && addr_q == PCS_IDX_HIGH_DRIVE) begin
         high_drive_enable_q <= cpu_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stop_wake_source_enable_q <= PCS_RST_ZERO;
      end else if (ctl_wr && addr_q == PCS_IDX_WAKE_SRC) begin
         stop_wake_source_enable_q <= cpu_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pullup_enable_q <= PULLUP_RESET;
      end else if (ctl_wr && addr_q == PCS_IDX_PULLUP) begin
         pullup_enable_q <= cpu_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alt_func_select_one_q <= PCS_RST_ZERO;
      end else if (ctl_wr && addr_q == PCS_IDX_ALT_SEL_ONE) begin
         alt_func_select_one_q <= cpu_wdata;
      end
   end

   // read mux; unmapped indices read as zero
   always_comb begin
      rd_d = PCS_RD_UNMAPPED;
      if (addr_rd) begin
         rd_d = addr_q;
      end else begin
         unique case (addr_q)
            PCS_IDX_ALT_ENABLE: rd_d = alt_func_enable_reg_q;
            PCS_IDX_OUT_CTRL: rd_d = output_control_reg_q;
            PCS_IDX_HIGH_DRIVE: rd_d = high_drive_enable_q;
            PCS_IDX_WAKE_SRC: rd_d = stop_wake_source_enable_q;
            PCS_IDX_PULLUP: rd_d = pullup_enable_q;
            PCS_IDX_ALT_SEL_ONE: rd_d = alt_func_select_one_q;
            default: rd_d = PCS_RD_UNMAPPED;
         endcase
      end
   end

   // read data held until the next read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpu_rdata_q <= PCS_RD_UNMAPPED;
      end else if (addr_rd || ctl_rd) begin
         cpu_rdata_q <= rd_d;
      end
   end

   // per pin: an enabled alternate function owns the driver,
   // otherwise the direction bit decides (1 = input, driver off)
   for (genvar p = 0; p < PCS_PINS; p++) begin : g_oe
      assign pin_output_en_d[p] = alt_func_enable_reg_q[p] ?
         alt_output_en[p] :
         ~pin_direction_bit[p];
   end

   // pin-side outputs: register state one edge after the write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_high_drive_q <= PCS_RST_ZERO;
         pin_pullup_q <= PULLUP_RESET;
         pin_source_en_q <= ~OUT_CTRL_RESET;
         pin_output_en_q <= PCS_RST_ZERO;
         pin_alt_active_q <= ALT_ENABLE_RESET;
         pin_alt_select_one_q <= PCS_RST_ZERO;
      end else begin
         // drive strength is not gated by alternate enable
         pin_high_drive_q <= high_drive_enable_q;
         pin_pullup_q <= pullup_enable_q;
         pin_source_en_q <= ~output_control_reg_q;
         pin_alt_active_q <= alt_func_enable_reg_q;
         // open drain only cuts the source; enable still follows the mux
         pin_output_en_q <= pin_output_en_d;
         pin_alt_select_one_q <= alt_func_select_one_q &
            alt_func_enable_reg_q;
      end
   end

   // wake held off for three edges after reset: sync2 and the detector
   // history start at zero, so a high pad would look like an edge;
   // limitation: no wake source counts that early
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wake_arm_q <= 3'h0;
      end else begin
         wake_arm_q <= {wake_arm_q[1:0], 1'h1};
      end
   end

   // two-stage synchroniser; only sync2 is looked at
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_q <= PCS_RST_ZERO;
         sync2_q <= PCS_RST_ZERO;
      end else begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
      end
   end

   assign wk.pin_level = sync2_q;
   assign wk.source_en = stop_wake_source_enable_q;
   assign wk.stop_mode = stop_mode & wake_arm_q[2];

   // wake detection lives in its own module behind the interface

   pcs_wake_detect u_wake (
      .clk(clk),
      .sys_rst(sys_rst),
      .wk(wk.det)
   );

   // pin edge to pulse costs three clocks of latency
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wake_req_q <= 1'b0;
      end else begin
         wake_req_q <= wk.wake;
      end
   end
endmodule

//--- bench/pcs_pad_model.sv
// pad model: bench-driven levels, pull-ups, floating pins
// assumes the bench sets ext_en on every pin it drives
`timescale 1ns/1ps
module pcs_pad_model(
   // clock and bench drive
   input logic clk,
   input logic [7:0] ext_en,
   input logic [7:0] ext_val,
   // device pull-ups and pad levels
   input logic [7:0] pin_pullup_q,
   output logic [7:0] pad_in
);
   logic [7:0] flt_q = 8'h5a;
   // an undriven pad without pull-up wanders, never trust its last level
   always @(posedge clk) flt_q <= ~flt_q;
   assign pad_in = ext_en & ext_val | ~ext_en & (pin_pullup_q | flt_q);
endmodule

//--- bench/pcs_port_cfg_props.sv
// assertions on the port configuration subregister ports
// assumes one clock with sync reset; bound below
`timescale 1ns/1ps
module pcs_port_cfg_props(
   // clock, reset, cpu side
   input logic clk,
   input logic sys_rst,
   input logic addr_wr,
   input logic addr_rd,
   input logic ctl_wr,
   input logic ctl_rd,
   input logic [7:0] cpu_wdata,
   input logic [7:0] cpu_rdata_q,
   // port side
   input logic [7:0] pin_direction_bit,
   input logic [7:0] alt_output_en,
   input logic stop_mode,
   input logic [7:0] pin_high_drive_q,
   input logic [7:0] pin_pullup_q,
   input logic [7:0] pin_source_en_q,
   input logic [7:0] pin_output_en_q,
   input logic [7:0] pin_alt_active_q,
   input logic [7:0] pin_alt_select_one_q,
   input logic wake_req_q
);
   logic [7:0] ix_q;
   // index shadow, the design keeps its copy internal
   always_ff @(posedge clk) begin
      if (sys_rst) ix_q <= 8'h00;
      else if (addr_wr) ix_q <= cpu_wdata;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property wr_p(logic [7:0] i, logic [7:0] q, logic [7:0] m);
      ctl_wr && ix_q == i |=> ##1 q == ($past(cpu_wdata, 2) ^ m);
   endproperty
   AST_HD: assert property (wr_p(8'h04, pin_high_drive_q, 8'h00))
      else $error("high drive");
   AST_PU: assert property (wr_p(8'h06, pin_pullup_q, 8'h00))
      else $error("pullup");
   AST_AE: assert property (wr_p(8'h02, pin_alt_active_q, 8'h00))
      else $error("alt enable");
   AST_OC: assert property (wr_p(8'h03, pin_source_en_q, 8'hff))
      else $error("open drain");
   AST_SEL: assert property (
      (pin_alt_select_one_q & ~pin_alt_active_q) == 8'h00)
      else $error("set one mask");
   AST_OE: assert property (!$past(sys_rst) |-> pin_output_en_q ==
      (pin_alt_active_q & $past(alt_output_en)
      | ~pin_alt_active_q & ~$past(pin_direction_bit))) else $error("oe");
   AST_WK: assert property (wake_req_q |-> $past(stop_mode))
      else $error("wake");
   AST_RD: assert property (
      ctl_rd && !ctl_wr && !addr_rd && ix_q == 8'h04
      |=> cpu_rdata_q == pin_high_drive_q) else $error("read");
   cover property (wake_req_q);
   cover property (ctl_wr && addr_wr);
   cover property (ctl_rd && ix_q == 8'h05);
   cover property (addr_rd && ctl_rd);
endmodule
bind pcs_port_cfg pcs_port_cfg_props pcs_port_cfg_props_i (.clk, .sys_rst,
   .addr_wr, .addr_rd, .ctl_wr, .ctl_rd, .cpu_wdata, .cpu_rdata_q,
   .pin_direction_bit, .alt_output_en, .stop_mode, .pin_high_drive_q,
   .pin_pullup_q, .pin_source_en_q, .pin_output_en_q, .pin_alt_active_q,
   .pin_alt_select_one_q, .wake_req_q);

//--- bench/tb_top.sv
// bench for the port configuration subregisters
// assumes port D reset values and the bound checker
`timescale 1ns/1ps
module tb_top;
   import pcs_pkg::*;
   logic clk, sys_rst, addr_wr, addr_rd, ctl_wr, ctl_rd, stop_mode, wake_req_q;
   logic [7:0] cpu_wdata, cpu_rdata_q, pin_direction_bit, alt_output_en;
   logic [7:0] pad_in, pin_high_drive_q, pin_pullup_q, pin_source_en_q;
   logic [7:0] pin_output_en_q, pin_alt_active_q, pin_alt_select_one_q;
   logic [7:0] ext_en, ext_val, ix;
   logic [7:0] exp [0:9];
   logic [31:0] lf;
   int failures, comparisons, cyc_n;
   pcs_port_cfg #(.PULLUP_RESET(PCS_RST_PORT_D),
      .ALT_ENABLE_RESET(PCS_RST_PORT_D), .OUT_CTRL_RESET(PCS_RST_PORT_D))
   pcs_port_cfg_i (.clk, .sys_rst, .addr_wr, .addr_rd, .ctl_wr, .ctl_rd,
      .cpu_wdata, .cpu_rdata_q, .pin_direction_bit, .alt_output_en,
      .stop_mode, .pad_in, .pin_high_drive_q, .pin_pullup_q,
      .pin_source_en_q, .pin_output_en_q, .pin_alt_active_q,
      .pin_alt_select_one_q, .wake_req_q);
   pcs_pad_model pcs_pad_model_i (.clk, .ext_en, .ext_val, .pin_pullup_q,
      .pad_in);
   always #10 clk = ~clk;
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // alternate enable hands the driver over, else direction decides
   function automatic logic [7:0] oe_exp(input logic [7:0] a);
      return (a & alt_output_en) | (~a & ~pin_direction_bit);
   endfunction
   task automatic stop_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 2000) begin
         failures++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, s);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   // strobes stay as set until the next call; one call may raise two at once (4'ha, 4'h5)
   task automatic cyc(input logic [3:0] st, input logic [7:0] d);
      {addr_wr, addr_rd, ctl_wr, ctl_rd} = st;
      cpu_wdata = d;
      @(negedge clk);
   endtask
   task automatic outs;
      chk("hd", exp[4], pin_high_drive_q);
      chk("pu", exp[6], pin_pullup_q);
      chk("src", ~exp[3], pin_source_en_q);
      chk("alt", exp[2], pin_alt_active_q);
      chk("sel", exp[7] & exp[2], pin_alt_select_one_q);
   endtask
   task automatic wk(input logic [7:0] t, input logic e);
      logic h;
      h = 1'b0;
      ext_val = ext_val ^ t;
      repeat (4) begin
         @(negedge clk);
         h = h | wake_req_q;
      end
      chk("wake", {7'h00, e}, {7'h00, h});
   endtask
   initial begin
      {clk, sys_rst, addr_wr, addr_rd, ctl_wr, ctl_rd, stop_mode} = 7'h20;
      {cpu_wdata, pin_direction_bit, alt_output_en, ext_val} = 32'h0;
      ext_en = 8'hff;
      lf = 32'hb1492ec0;
      exp = '{default: 8'h00};
      exp[2] = PCS_RST_PORT_D;
      exp[3] = PCS_RST_PORT_D;
      exp[6] = PCS_RST_PORT_D;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      outs();
      for (int i = 0; i < 70; i++) begin
         ix = (i < 10) ? 8'(i) : 8'(lf[10:8]) + 8'h01;
         lf = nx(lf);
         pin_direction_bit = lf[23:16];
         alt_output_en = lf[31:24];
         cyc(4'h8, ix);
         if (i >= 10) cyc(4'h2, lf[7:0]);
         if (i >= 10 && ix inside {[2:7]}) exp[ix] = lf[7:0];
         cyc(4'h1, 8'h00);
         cyc(4'h0, 8'h00);
         chk("rd", exp[ix], cpu_rdata_q);
         outs();
         chk("oe", oe_exp(exp[2]), pin_output_en_q);
      end
      cyc(4'h8, 8'h04);
      cyc(4'ha, 8'h3c);
      exp[4] = 8'h3c;
      cyc(4'h8, 8'h05);
      cyc(4'h2, 8'h01);
      cyc(4'h0, 8'h00);
      outs();
      cyc(4'h5, 8'h00);
      cyc(4'h0, 8'h00);
      chk("idx", 8'h05, cpu_rdata_q);
      stop_mode = 1'b1;
      wk(8'h01, 1'b1);
      wk(8'h02, 1'b0);
      wk(8'h01, 1'b1);
      stop_mode = 1'b0;
      wk(8'h01, 1'b0);
      stop_test();
   end
endmodule
